// >>> core/atm_pkg.sv
package atm_pkg;

  // channel population: physical inputs first, then virtual ones
  localparam int NUM_PHYS = 7;
  localparam int NUM_VIRT = 8;
  localparam int NUM_CH   = NUM_PHYS + NUM_VIRT;
  localparam int NUM_INT  = 16;
  localparam int NUM_QTY  = 3;
  localparam int NUM_DIN  = 8;

  // timing: delays are counted in milliseconds
  localparam int CLK_HZ        = 25_000_000;
  localparam int DELAY_UNIT_MS = 1;
  localparam int MS_CYCLES     = CLK_HZ / 1000 * DELAY_UNIT_MS;

  // register map (global byte addresses, then channel block and word indices)
  localparam logic [11:0] REG_SUMMARY     = 12'h000;
  localparam logic [11:0] REG_INHIBIT_MAP = 12'h004;
  localparam logic [5:0]  CH_FIRST_BLK    = 6'h04;
  localparam logic [3:0]  CH_FUNC   = 4'h0;
  localparam logic [3:0]  CH_LIMIT0 = 4'h1;
  localparam logic [3:0]  CH_LIMIT1 = 4'h2;
  localparam logic [3:0]  CH_DELAY0 = 4'h3;
  localparam logic [3:0]  CH_DELAY1 = 4'h4;
  localparam logic [3:0]  CH_OPT0   = 4'h5;
  localparam logic [3:0]  CH_OPT1   = 4'h6;
  localparam logic [3:0]  CH_STATUS = 4'h7;
  localparam logic [3:0]  CH_VALUE  = 4'h8;
  localparam logic [3:0]  CH_VIRT   = 4'h9;

  // reset values
  localparam logic [15:0] FUNC_RESET = 16'h0000;
  localparam logic [15:0] DELAY_RESET = 16'h0000;
  localparam logic [16:0] OPT_RESET  = 17'h00000;
  localparam logic [7:0]  INHIBIT_MAP_RESET = 8'h00;

  // function codes (decimal code carried as its binary value)
  localparam logic [15:0] FUNCTION_UNUSED           = 16'h0000;
  localparam logic [15:0] FUNCTION_AS_DISCRETE_INPUT = 16'h0064;
  localparam logic [15:0] CURVE_OIL_PRESSURE        = 16'h03E8;
  localparam logic [15:0] CURVE_OIL_TEMPERATURE     = 16'h044C;
  localparam logic [15:0] CURVE_COOLANT_TEMPERATURE = 16'h0456;
  localparam logic [15:0] FUNCTION_EXTERNAL_MANAGED = 16'h0803;
  localparam logic [15:0] VIRTUAL_COPY_BOUNDARY     = 16'h0FA0;

  // option word bit positions
  localparam int OPT_LOWER    = 0;
  localparam int OPT_HYST_SET = 1;
  localparam int OPT_WARN     = 4;
  localparam int OPT_UNLOAD   = 5;
  localparam int OPT_DEACT    = 6;
  localparam int OPT_SHUTDOWN = 7;
  localparam int OPT_RUN      = 8;
  localparam int OPT_OILMASK  = 9;
  localparam int OPT_BREAKER  = 10;
  localparam int OPT_FUEL     = 11;
  localparam int OPT_GAS      = 12;
  localparam int OPT_INHIBIT  = 13;
  localparam int OPT_PUMP     = 14;
  localparam int OPT_OVERRIDE = 16;

  // hardware kind of a physical reading
  localparam logic [1:0] KIND_VOLT = 2'h0;
  localparam logic [1:0] KIND_RES  = 2'h1;
  localparam logic [1:0] KIND_TC   = 2'h2;
  localparam logic [1:0] KIND_TEMP = 2'h3;

  // thermocouple limits in units of 0.1 mV
  localparam logic signed [15:0] TC_OPEN  = 16'sh04B0;
  localparam logic signed [15:0] TC_OVER  = 16'sh03E8;
  localparam logic signed [15:0] TC_UNDER = -16'sh0064;

  // sender curves: ohms against tenths of the unit, 4 points each
  localparam int CURVE_R [NUM_QTY][4] = '{
    '{32'h0CA8, 32'h0142, 32'h003E, 32'h0013},
    '{32'h0708, 32'h00C3, 32'h0026, 32'h0016},
    '{32'h000A, 32'h0056, 32'h00B4, 32'h00B4}};
  localparam int CURVE_Y [NUM_QTY][4] = '{
    '{32'h0000, 32'h01F4, 32'h03E8, 32'h05DC},
    '{32'h0000, 32'h01F4, 32'h03E8, 32'h04B0},
    '{32'h0000, 32'h0028, 32'h0064, 32'h0064}};

  typedef struct packed {
    logic [1:0]         kind;
    logic               fe_open;
    logic               fe_over;
    logic               fe_under;
    logic signed [15:0] value;
  } atm_meas_t;

  typedef struct packed {
    logic running;
    logic oil_mask_done;
    logic breaker_closed;
    logic fuel_valve_on;
    logic gas_valve_on;
    logic override;
  } atm_plant_t;

  typedef struct packed {
    logic fuel_pump_off;
    logic shutdown;
    logic deactivate;
    logic unload;
    logic warning;
  } atm_anom_t;

  typedef struct packed {
    logic       valid;
    logic       global;
    logic [3:0] ch;
    logic [3:0] idx;
  } atm_dec_t;

endpackage

// >>> core/atm_monitor.sv
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
// How it works
// RULE_01: every channel has two comparators with own limit, delay, options
// RULE_02: reported comparator state flips only after its delay has elapsed
// RULE_03: option bit 0 picks above-limit or below-limit as out of limit
// RULE_04: option bit 1 chooses which comparator sets or resets hysteresis
// RULE_05: bits 4, 5, 6, 7 raise warning, unload, deactivation, shutdown
// RULE_06: bit 8 gates the anomaly on engine running
// RULE_07: bit 9 gates the anomaly on expired oil-pressure masking
// RULE_08: bit 10 gates the anomaly on a closed generator breaker
// RULE_09: bit 11 gates the anomaly on an active fuel valve
// RULE_10: bit 12 gates the anomaly on an active gas valve
// RULE_11: bit 13 gates the anomaly on no active protection-inhibit input
// RULE_12: bit 14 makes a raised anomaly force the fuel pump off
// RULE_13: bit 16 lets the protection override suppress the anomaly
// RULE_14: all option bits work together in any combination
// RULE_15: locally measured quantity wins over the engine control value
// RULE_16: discrete-input function only on inputs 1 to 7, no analogue use
// RULE_17: externally managed function only on inputs 1 to 7, value unused
// RULE_18: virtual above boundary copies internal value for comparators
// RULE_19: selected sender curve maps resistance to engineering value
// RULE_20: oil-pressure curve maps 0, 4, 10 bar to its resistances
// RULE_21: virtual and temperature inputs skip the sender curve
// RULE_22: flag each reading as open, positive or negative overrange
// RULE_23: thermocouple over 120 mV open, over 100 overflow, below -10 under
// RULE_24: condition reverting before the delay restarts the timer
// RULE_25: interpolate linearly between curve points, clamp beyond the ends
module atm_monitor #(
  parameter int MS_CYCLES = atm_pkg::MS_CYCLES
) (
  // clock and reset
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // apb slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [11:0]                paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // measurements and plant state
  input  wire atm_pkg::atm_meas_t         meas [atm_pkg::NUM_PHYS],
  input  wire logic signed [15:0]         int_meas [atm_pkg::NUM_INT],
  input  wire logic signed [15:0]         ecu_value [atm_pkg::NUM_QTY],
  input  wire atm_pkg::atm_plant_t        plant,
  input  wire logic [atm_pkg::NUM_DIN-1:0] protection_inhibit_input,
  // results
  output atm_pkg::atm_anom_t              anomaly,
  output logic [atm_pkg::NUM_PHYS-1:0]    discrete_mode,
  output logic signed [15:0]              qty_value [atm_pkg::NUM_QTY]
);

  localparam int NCH = atm_pkg::NUM_CH;

  // configuration registers
  logic [15:0]        func_reg  [NCH];
  logic signed [15:0] lim_reg   [NCH][2];
  logic [15:0]        dly_reg   [NCH][2];
  logic [16:0]        opt_reg   [NCH][2];
  logic signed [15:0] virt_reg  [NCH];
  logic [7:0]         inhibit_map_reg;

  // channel state
  logic signed [15:0] value_reg [NCH];
  logic [2:0]         elec_reg  [NCH];
  logic               out_st    [NCH][2];
  logic               hyst_reg  [NCH];
  atm_pkg::atm_anom_t ch_anom   [NCH];
  logic               ch_active [NCH];

  logic [7:0]         din_meta_reg;
  logic [7:0]         din_sync_reg;
  logic [15:0]        tick_cnt_reg;
  logic               tick;
  logic               inhibit_any;
  atm_pkg::atm_anom_t anom_next;
  atm_pkg::atm_dec_t  dec;
  logic [31:0]        rd_next;

  function automatic atm_pkg::atm_dec_t decode(input logic [11:0] a);
    atm_pkg::atm_dec_t d;
    logic [5:0]        blk;
    d   = '0;
    blk = a[11:6];
    d.idx = a[5:2];
    if (a[11:8] == 4'h0) begin
      d.global = 1'b1;
      d.valid  = (a == atm_pkg::REG_SUMMARY) ||
                 (a == atm_pkg::REG_INHIBIT_MAP);
    end else if (blk >= atm_pkg::CH_FIRST_BLK &&
                 blk < atm_pkg::CH_FIRST_BLK + 6'(NCH)) begin
      d.ch    = 4'(blk - atm_pkg::CH_FIRST_BLK);
      d.valid = (a[5:2] <= atm_pkg::CH_VIRT) && (a[1:0] == 2'h0);
    end
    return d;
  endfunction

  // curve index for a function code, -1 when it names no curve
  function automatic int curve_of(input logic [15:0] f);
    case (f)
      atm_pkg::CURVE_OIL_TEMPERATURE:     curve_of = 0;
      atm_pkg::CURVE_COOLANT_TEMPERATURE: curve_of = 1;
      atm_pkg::CURVE_OIL_PRESSURE:        curve_of = 2;
      default:                            curve_of = -1;
    endcase
  endfunction

  function automatic logic signed [15:0] curve_eval(input int c,
                                                    input int r);
    int y;
    int dir;
    y   = atm_pkg::CURVE_Y[c][3];
    dir = atm_pkg::CURVE_R[c][3] - atm_pkg::CURVE_R[c][0];
    // clamp on either end, works for rising and falling senders
    if ((r - atm_pkg::CURVE_R[c][0]) * dir <= 0) begin // RULE_25
      y = atm_pkg::CURVE_Y[c][0];
    end else if ((r - atm_pkg::CURVE_R[c][3]) * dir >= 0) begin
      y = atm_pkg::CURVE_Y[c][3];
    end else begin
      for (int i = 2; i >= 0; i--) begin
        // duplicate points pad short curves and are skipped
        if (atm_pkg::CURVE_R[c][i] != atm_pkg::CURVE_R[c][i+1] &&
            (r - atm_pkg::CURVE_R[c][i]) * dir >= 0) begin
          y = atm_pkg::CURVE_Y[c][i] +
              (r - atm_pkg::CURVE_R[c][i]) *
              (atm_pkg::CURVE_Y[c][i+1] - atm_pkg::CURVE_Y[c][i]) /
              (atm_pkg::CURVE_R[c][i+1] - atm_pkg::CURVE_R[c][i]); // RULE_25
          break;
        end
      end
    end
    return 16'(y); // RULE_19 RULE_20
  endfunction

  function automatic logic gate_ok(input logic [16:0] o,
                                   input atm_pkg::atm_plant_t p,
                                   input logic inh);
    gate_ok = (!o[atm_pkg::OPT_RUN]      || p.running) &&         // RULE_06
              (!o[atm_pkg::OPT_OILMASK]  || p.oil_mask_done) &&   // RULE_07
              (!o[atm_pkg::OPT_BREAKER]  || p.breaker_closed) &&  // RULE_08
              (!o[atm_pkg::OPT_FUEL]     || p.fuel_valve_on) &&   // RULE_09
              (!o[atm_pkg::OPT_GAS]      || p.gas_valve_on) &&    // RULE_10
              (!o[atm_pkg::OPT_INHIBIT]  || !inh) &&              // RULE_11
              (!o[atm_pkg::OPT_OVERRIDE] || !p.override);         // RULE_13
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_reg <= 16'h0000;
    end else if (tick) begin
      tick_cnt_reg <= 16'h0000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 16'h0001;
    end
  end
  assign tick = (tick_cnt_reg == 16'(MS_CYCLES - 1));

  // digital inputs come from pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      din_meta_reg <= 8'h00;
      din_sync_reg <= 8'h00;
    end else begin
      din_meta_reg <= protection_inhibit_input;
      din_sync_reg <= din_meta_reg;
    end
  end
  // unmapped inputs never inhibit, so no mapping means always allowed
  assign inhibit_any = |(din_sync_reg & inhibit_map_reg); // RULE_11

  assign dec    = decode(paddr);
  assign pready = 1'b1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inhibit_map_reg <= atm_pkg::INHIBIT_MAP_RESET;
      for (int c = 0; c < NCH; c++) begin
        func_reg[c] <= atm_pkg::FUNC_RESET;
        virt_reg[c] <= 16'sh0000;
        for (int k = 0; k < 2; k++) begin
          lim_reg[c][k] <= 16'sh0000;
          dly_reg[c][k] <= atm_pkg::DELAY_RESET;
          opt_reg[c][k] <= atm_pkg::OPT_RESET;
        end
      end
    end else if (psel && penable && pwrite && dec.valid) begin
      if (dec.global) begin
        if (paddr == atm_pkg::REG_INHIBIT_MAP) begin
          inhibit_map_reg <= pwdata[7:0];
        end
      end else begin
        case (dec.idx)
          atm_pkg::CH_FUNC: begin
            // codes that do not fit the channel type are refused
            if (int'(dec.ch) < atm_pkg::NUM_PHYS) begin
              if (pwdata[15:0] <= atm_pkg::VIRTUAL_COPY_BOUNDARY) begin
                func_reg[dec.ch] <= pwdata[15:0];
              end
            end else if (pwdata[15:0] !=
                           atm_pkg::FUNCTION_AS_DISCRETE_INPUT && // RULE_16
                         pwdata[15:0] !=
                           atm_pkg::FUNCTION_EXTERNAL_MANAGED) begin // RULE_17
              func_reg[dec.ch] <= pwdata[15:0];
            end
          end
          atm_pkg::CH_LIMIT0: lim_reg[dec.ch][0] <= pwdata[15:0];
          atm_pkg::CH_LIMIT1: lim_reg[dec.ch][1] <= pwdata[15:0];
          atm_pkg::CH_DELAY0: dly_reg[dec.ch][0] <= pwdata[15:0];
          atm_pkg::CH_DELAY1: dly_reg[dec.ch][1] <= pwdata[15:0];
          atm_pkg::CH_OPT0:   opt_reg[dec.ch][0] <= pwdata[16:0];
          atm_pkg::CH_OPT1:   opt_reg[dec.ch][1] <= pwdata[16:0];
          atm_pkg::CH_VIRT:   virt_reg[dec.ch]   <= pwdata[15:0];
          default: ;
        endcase
      end
    end
  end

  always_comb begin
    rd_next = 32'h0000_0000;
    if (dec.valid && dec.global) begin
      if (paddr == atm_pkg::REG_SUMMARY) begin
        rd_next = {26'h0000000, inhibit_any, anomaly};
      end else begin
        rd_next = {24'h000000, inhibit_map_reg};
      end
    end else if (dec.valid) begin
      case (dec.idx)
        atm_pkg::CH_FUNC:   rd_next = {16'h0000, func_reg[dec.ch]};
        atm_pkg::CH_LIMIT0: rd_next = {16'h0000, lim_reg[dec.ch][0]};
        atm_pkg::CH_LIMIT1: rd_next = {16'h0000, lim_reg[dec.ch][1]};
        atm_pkg::CH_DELAY0: rd_next = {16'h0000, dly_reg[dec.ch][0]};
        atm_pkg::CH_DELAY1: rd_next = {16'h0000, dly_reg[dec.ch][1]};
        atm_pkg::CH_OPT0:   rd_next = {15'h0000, opt_reg[dec.ch][0]};
        atm_pkg::CH_OPT1:   rd_next = {15'h0000, opt_reg[dec.ch][1]};
        atm_pkg::CH_STATUS: rd_next = {19'h00000, ch_anom[dec.ch],
                                       1'b0, ch_active[dec.ch],
                                       elec_reg[dec.ch], hyst_reg[dec.ch],
                                       out_st[dec.ch][1], out_st[dec.ch][0]};
        atm_pkg::CH_VALUE:  rd_next = {{16{value_reg[dec.ch][15]}},
                                       value_reg[dec.ch]};
        atm_pkg::CH_VIRT:   rd_next = {16'h0000, virt_reg[dec.ch]};
        default:            rd_next = 32'h0000_0000;
      endcase
    end
  end

  // read data is caught in the setup cycle so the access needs no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata  <= pwrite ? 32'h0000_0000 : rd_next;
      pslverr <= !dec.valid;
    end
  end

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    logic signed [15:0] conv;
    logic [2:0]         elec;
    int                 cidx;

    assign cidx = curve_of(func_reg[g]);
    // unused, discrete and externally managed inputs stay out of control
    assign ch_active[g] =
      func_reg[g] != atm_pkg::FUNCTION_UNUSED &&
      func_reg[g] != atm_pkg::FUNCTION_AS_DISCRETE_INPUT && // RULE_16
      func_reg[g] != atm_pkg::FUNCTION_EXTERNAL_MANAGED;    // RULE_17

    if (g < atm_pkg::NUM_PHYS) begin : g_phys
      always_comb begin
        conv = meas[g].value;
        // only resistive physical readings go through a curve
        if (cidx >= 0 && meas[g].kind == atm_pkg::KIND_RES) begin // RULE_21
          conv = curve_eval(cidx, int'(meas[g].value));           // RULE_19
        end
      end
      always_comb begin
        if (meas[g].kind == atm_pkg::KIND_TC) begin // RULE_23
          elec = {meas[g].value < atm_pkg::TC_UNDER,
                  meas[g].value > atm_pkg::TC_OVER &&
                    meas[g].value <= atm_pkg::TC_OPEN,
                  meas[g].value > atm_pkg::TC_OPEN};
        end else begin
          elec = {meas[g].fe_under, meas[g].fe_over, meas[g].fe_open};
        end
      end
      assign discrete_mode[g] =
        (func_reg[g] == atm_pkg::FUNCTION_AS_DISCRETE_INPUT); // RULE_16
    end else begin : g_virt
      logic [15:0] sel;
      assign sel  = func_reg[g] - atm_pkg::VIRTUAL_COPY_BOUNDARY - 16'h0001;
      assign conv = (func_reg[g] > atm_pkg::VIRTUAL_COPY_BOUNDARY) ?
                    int_meas[sel[3:0]] : virt_reg[g]; // RULE_18 RULE_21
      assign elec = 3'h0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        value_reg[g] <= 16'sh0000;
        elec_reg[g]  <= 3'h0;
      end else begin
        value_reg[g] <= conv;
        elec_reg[g]  <= elec; // RULE_22
      end
    end

    // two comparators that share nothing but the channel value
    for (genvar k = 0; k < 2; k++) begin : g_cmp // RULE_01
      logic [15:0] cnt_reg;
      logic        cond;
      assign cond = opt_reg[g][k][atm_pkg::OPT_LOWER] ?
                    (value_reg[g] < lim_reg[g][k]) :
                    (value_reg[g] > lim_reg[g][k]); // RULE_03
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          out_st[g][k] <= 1'b0;
          cnt_reg      <= 16'h0000;
        end else if (!ch_active[g]) begin
          out_st[g][k] <= 1'b0;
          cnt_reg      <= 16'h0000;
        end else if (cond == out_st[g][k]) begin
          cnt_reg <= 16'h0000; // RULE_24
        end else if (cnt_reg >= dly_reg[g][k]) begin
          out_st[g][k] <= cond; // RULE_02
          cnt_reg      <= 16'h0000;
        end else if (tick) begin
          cnt_reg <= cnt_reg + 16'h0001;
        end
      end
    end

    // set wins when both comparators call at once
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        hyst_reg[g] <= 1'b0;
      end else if (out_st[g][0] && opt_reg[g][0][atm_pkg::OPT_HYST_SET] ||
                   out_st[g][1] && opt_reg[g][1][atm_pkg::OPT_HYST_SET]) begin
        hyst_reg[g] <= 1'b1; // RULE_04
      end else if (out_st[g][0] && !opt_reg[g][0][atm_pkg::OPT_HYST_SET] ||
                   out_st[g][1] && !opt_reg[g][1][atm_pkg::OPT_HYST_SET]) begin
        hyst_reg[g] <= 1'b0; // RULE_04
      end
    end

    always_comb begin
      ch_anom[g] = '0;
      for (int k = 0; k < 2; k++) begin
        if (out_st[g][k] && gate_ok(opt_reg[g][k], plant, inhibit_any)) begin
          // every enabled class and side effect applies together
          ch_anom[g] |= {opt_reg[g][k][atm_pkg::OPT_PUMP], // RULE_12
                         opt_reg[g][k][atm_pkg::OPT_SHUTDOWN:
                                       atm_pkg::OPT_WARN]}; // RULE_05
        end
      end
    end // RULE_14
  end

  always_comb begin
    anom_next = '0;
    for (int c = 0; c < NCH; c++) begin
      anom_next = anom_next | ch_anom[c]; // RULE_05
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      anomaly <= '0;
    end else begin
      anomaly <= anom_next;
    end
  end

  // a configured local input beats the engine control unit figure
  for (genvar q = 0; q < atm_pkg::NUM_QTY; q++) begin : g_qty
    logic signed [15:0] pick;
    always_comb begin
      pick = ecu_value[q];
      for (int c = NCH - 1; c >= 0; c--) begin
        if (ch_active[c] && curve_of(func_reg[c]) == q) begin
          pick = value_reg[c]; // RULE_15
        end
      end
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        qty_value[q] <= 16'sh0000;
      end else begin
        qty_value[q] <= pick;
      end
    end
  end

endmodule

// >>> tb/atm_chk_monitor.sv
`timescale 1ns/1ps
module atm_chk (
  // clock and reset
  input wire logic                  pclk,
  input wire logic                  presetn,
  // apb
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [11:0]           paddr,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  // results
  input wire atm_pkg::atm_anom_t    anomaly,
  input wire logic [6:0]            discrete_mode
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rd_setup = psel && !penable && !pwrite;
  a_ready_high:
    assert property (pready) else $error("pready dropped");
  a_misalign_err:
    assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
    else $error("misaligned access not refused");
  a_err_reads_zero:
    assert property (psel && penable && !pwrite && pslverr |-> prdata == 0)
    else $error("refused read not zero");
  a_func_mapped:
    assert property (psel && !penable && paddr[11:8] == 4'h1
      && paddr[5:0] == 6'h00 |=> !pslverr) else $error("function refused");
  a_summary_mirror:
    assert property (rd_setup && paddr == atm_pkg::REG_SUMMARY |=>
      prdata[4:0] == $past(anomaly) && prdata[31:6] == 26'h0)
    else $error("summary differs from anomaly");
  a_map_readable:
    assert property (rd_setup && paddr == atm_pkg::REG_INHIBIT_MAP |=>
      !pslverr && prdata[31:8] == 24'h0) else $error("map read bad");
  a_data_holds:
    assert property ($changed(prdata) |-> $past(psel && !penable))
    else $error("read data moved outside setup");
  a_discrete_by_write:
    assert property ($changed(discrete_mode) |->
      $past(psel && penable && pwrite)) else $error("discrete mode moved");
  c_refused: cover property (psel && penable && pslverr);
  c_shutdown: cover property (anomaly.shutdown);
  c_discrete: cover property (|discrete_mode);
endmodule
bind atm_monitor atm_chk atm_chk_i (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .anomaly, .discrete_mode);

// >>> tb/atm_plant_src.sv
`timescale 1ns/1ps
// sensors, engine control unit and plant levels, changed after an edge
module atm_plant_src (
  // clock
  input  wire logic                    pclk,
  // toward the monitor
  output atm_pkg::atm_meas_t           meas [atm_pkg::NUM_PHYS],
  output logic signed [15:0]           int_meas [atm_pkg::NUM_INT],
  output logic signed [15:0]           ecu_value [atm_pkg::NUM_QTY],
  output atm_pkg::atm_plant_t          plant,
  output logic [atm_pkg::NUM_DIN-1:0]  inhibit
);
  initial begin
    foreach (meas[i]) meas[i] = '0;
    foreach (int_meas[i]) int_meas[i] = 16'sh0100;
    foreach (ecu_value[i]) ecu_value[i] = 16'sh007B;
    plant = '0;
    inhibit = '0;
  end
  task automatic set_ch(input int c, input logic [1:0] k,
                        input logic signed [15:0] v);
    @(posedge pclk);
    meas[c] <= '{kind: k, value: v, default: 1'b0};
  endtask
  task automatic set_plant(input logic [5:0] p, input logic [7:0] d);
    @(posedge pclk);
    plant <= p;
    inhibit <= d;
  endtask
endmodule

// >>> tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic                pclk, presetn, psel, penable, pwrite, pready;
  logic                pslverr, err;
  logic [11:0]         paddr;
  logic [31:0]         pwdata, prdata, rd;
  atm_pkg::atm_meas_t  meas [atm_pkg::NUM_PHYS];
  logic signed [15:0]  int_meas [atm_pkg::NUM_INT];
  logic signed [15:0]  ecu_value [atm_pkg::NUM_QTY];
  logic signed [15:0]  qty_value [atm_pkg::NUM_QTY];
  atm_pkg::atm_plant_t plant;
  atm_pkg::atm_anom_t  anomaly;
  logic [7:0]          inh;
  logic [6:0]          discrete_mode;
  int                  mismatches, num_checks, cyc;
  // short ms tick keeps delay tests to tens of cycles
  atm_monitor #(.MS_CYCLES(10)) atm_monitor_i (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .meas,
    .int_meas, .ecu_value, .plant, .protection_inhibit_input(inh),
    .anomaly, .discrete_mode, .qty_value);
  atm_plant_src atm_plant_src_i (.pclk, .meas, .int_meas, .ecu_value,
    .plant, .inhibit(inh));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic conclude;
    if (mismatches == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input string n, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic logic [11:0] ca(input int c, input logic [3:0] r);
    return 12'(256 + c * 64 + r * 4);
  endfunction
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic t_apb;
    xfer(1'b0, 12'h002, 32'h0);
    check("refused error", 32'h1, 32'(err));
    check("refused data", 32'h0, rd);
    xfer(1'b1, ca(0, atm_pkg::CH_FUNC), 32'h64);
    @(posedge pclk);
    check("discrete mode", 32'h1, 32'(discrete_mode));
    xfer(1'b1, ca(7, atm_pkg::CH_FUNC), 32'h64);
    xfer(1'b0, ca(7, atm_pkg::CH_FUNC), 32'h0);
    check("virtual function", 32'h0, rd);
  endtask
  task automatic t_curve;
    logic signed [15:0] r [3] = '{16'sd500, 16'sd86, 16'sd133};
    logic signed [15:0] e [3] = '{16'sd100, 16'sd40, 16'sd70};
    check("ecu quantity", 32'h7B, 32'(qty_value[2]));
    xfer(1'b1, ca(1, atm_pkg::CH_FUNC), 32'h03E8);
    foreach (r[i]) begin
      atm_plant_src_i.set_ch(1, atm_pkg::KIND_RES, r[i]);
      repeat (4) @(posedge pclk);
      check("oil pressure", 32'(e[i]), 32'(qty_value[2]));
    end
    atm_plant_src_i.set_ch(3, atm_pkg::KIND_RES, 16'sd322);
    xfer(1'b1, ca(3, atm_pkg::CH_FUNC), 32'h044C);
    repeat (4) @(posedge pclk);
    check("oil temperature", 32'h1F4, 32'(qty_value[0]));
  endtask
  task automatic t_cmp;
    xfer(1'b1, ca(1, atm_pkg::CH_DELAY0), 32'h2);
    xfer(1'b1, ca(1, atm_pkg::CH_LIMIT0), 32'd200);
    xfer(1'b1, ca(1, atm_pkg::CH_OPT0), 32'h90);
    repeat (60) @(posedge pclk);
    check("in limit", 32'h0, 32'(anomaly));
    xfer(1'b1, ca(1, atm_pkg::CH_LIMIT0), 32'd50);
    repeat (5) @(posedge pclk);
    check("early anomaly", 32'h0, 32'(anomaly));
    repeat (40) @(posedge pclk);
    check("warn shutdown", 32'h09, 32'(anomaly));
    xfer(1'b1, ca(1, atm_pkg::CH_LIMIT1), 32'd80);
    xfer(1'b1, ca(1, atm_pkg::CH_OPT1), 32'h43);
    repeat (6) @(posedge pclk);
    check("lower sense", 32'h0D, 32'(anomaly));
    xfer(1'b0, ca(1, atm_pkg::CH_STATUS), 32'h0);
    check("hysteresis", 32'h7, 32'(rd[2:0]));
    xfer(1'b1, ca(1, atm_pkg::CH_OPT1), 32'h0);
  endtask
  // each gate is shown closed, then open
  task automatic t_gate;
    logic [16:0] o [14] = '{17'h110, 17'h110, 17'h210, 17'h210, 17'h410,
      17'h410, 17'h810, 17'h810, 17'h1010, 17'h1010, 17'h14010, 17'h14010,
      17'h2010, 17'h2010};
    logic [5:0] p [14] = '{6'h1E, 6'h3E, 6'h2E, 6'h3E, 6'h36, 6'h3E, 6'h3A,
      6'h3E, 6'h3C, 6'h3E, 6'h01, 6'h00, 6'h00, 6'h00};
    int e [14] = '{0, 1, 0, 1, 0, 1, 0, 1, 0, 1, 0, 'h11, 0, 1};
    xfer(1'b1, atm_pkg::REG_INHIBIT_MAP, 32'h1);
    xfer(1'b0, atm_pkg::REG_INHIBIT_MAP, 32'h0);
    check("inhibit map", 32'h1, rd);
    foreach (o[i]) begin
      xfer(1'b1, ca(1, atm_pkg::CH_OPT0), 32'(o[i]));
      atm_plant_src_i.set_plant(p[i], {7'h0, i == 12});
      repeat (8) @(posedge pclk);
      check("gated anomaly", 32'(e[i]), 32'(anomaly));
    end
    xfer(1'b0, atm_pkg::REG_SUMMARY, 32'h0);
    check("summary", 32'h1, rd);
  endtask
  task automatic t_tc;
    logic signed [15:0] v [5] = '{16'sd1201, 16'sd1200, 16'sd1000,
      -16'sd100, -16'sd101};
    logic [2:0] e [5] = '{3'h1, 3'h2, 3'h0, 3'h0, 3'h4};
    xfer(1'b1, ca(2, atm_pkg::CH_FUNC), 32'h07D1);
    foreach (v[i]) begin
      atm_plant_src_i.set_ch(2, atm_pkg::KIND_TC, v[i]);
      repeat (3) @(posedge pclk);
      xfer(1'b0, ca(2, atm_pkg::CH_STATUS), 32'h0);
      check("fault flags", 32'(e[i]), 32'(rd[5:3]));
    end
  endtask
  initial begin
    {psel, penable, pwrite, presetn} = '0;
    paddr = '0;
    pwdata = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_apb();
    t_curve();
    t_cmp();
    t_gate();
    t_tc();
    conclude();
  end
endmodule
